// [hdl/pwm_map.vh]
// Register map, field positions and reset values of the pulse-width modulator
`ifndef PWM_MAP_VH
`define PWM_MAP_VH

`define PWM_NCH 6
`define PWM_NOUT 4
`define PWM_NPAIR 3

`define PWM_CTRL_OFF 8'h00
`define PWM_CLKSEL_OFF 8'h04
`define PWM_PRESC_OFF 8'h08
`define PWM_STAT_OFF 8'h0C
`define PWM_PER_BASE 8'h10
`define PWM_DUTY_BASE 8'h28
`define PWM_CNT_BASE 8'h40
`define PWM_MAP_END 8'h58

`define PWM_EN_LSB 0
`define PWM_POL_LSB 8
`define PWM_CTR_LSB 16
`define PWM_CAT_LSB 24
`define PWM_AEXP_LSB 0
`define PWM_BEXP_LSB 4
`define PWM_SCLA_LSB 8
`define PWM_SCLB_LSB 16
`define PWM_OUT_LSB 8

`define PWM_EN_RST 6'h00
`define PWM_POL_RST 6'h3F
`define PWM_CTR_RST 6'h00
`define PWM_CAT_RST 3'h0
`define PWM_CLKSEL_RST 12'h000
`define PWM_EXP_RST 3'h0
`define PWM_SCL_RST 8'h01
`define PWM_PER_RST 8'hFF
`define PWM_DUTY_RST 8'h00

`define PWM_RESP_OKAY 2'h0
`define PWM_RESP_SLVERR 2'h2

`endif

// [hdl/pwm_clkgen.v]
// Prescaler producing the four counter clock ticks: primary A, B and scaled A, B
`timescale 1ns/1ps
`include "pwm_map.vh"

module pwm_clkgen (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Settings
  input wire [2:0] a_exp,
  input wire [2:0] b_exp,
  input wire [7:0] scl_a,
  input wire [7:0] scl_b,
  // Ticks, bit 0 A, 1 B, 2 scaled_clock_first, 3 scaled_clock_second
  output wire [3:0] tick
);
  reg [7:0] pre_q;
  wire [5:0] exps = {b_exp, a_exp};
  wire [15:0] scls = {scl_b, scl_a};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_src
      wire [7:0] mask = ~(8'hFF << exps[3*k +: 3]);
      wire prim = (pre_q & mask) == mask;
      // Scale of zero divides by 512 rather than stopping the source
      wire [9:0] lim = {(scls[8*k +: 8] == 8'h00), scls[8*k +: 8], 1'b0} - 10'h001;
      reg [9:0] s_q;
      reg tp_q;
      reg ts_q;
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          s_q <= 10'h000;
          tp_q <= 1'b0;
          ts_q <= 1'b0;
        end else begin
          tp_q <= prim;
          ts_q <= prim & (s_q >= lim);
          if (prim) begin
            s_q <= (s_q >= lim) ? 10'h000 : s_q + 10'h001;
          end
        end
      end
      assign tick[k] = tp_q;
      assign tick[k+2] = ts_q;
    end
  endgenerate
endmodule // pwm_clkgen

// [hdl/pwm_chan.v]
// One modulator channel: double-buffered period and duty, left or centre aligned counter
`timescale 1ns/1ps
`include "pwm_map.vh"

module pwm_chan (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Control
  input wire tick,
  input wire en,
  input wire pol,
  input wire centre,
  input wire [15:0] per_buf,
  input wire [15:0] dut_buf,
  // Results
  output reg wave_q,
  output reg [15:0] cnt_q
);
  reg [15:0] per_q;
  reg [15:0] dut_q;
  reg down_q;
  wire [16:0] cnt_inc = {1'b0, cnt_q} + 17'h00001;
  wire at_top = cnt_inc >= {1'b0, per_q};
  // Duty at or above period saturates to fully on; zero duty never asserts
  wire duty_on = (cnt_q < dut_q) | (centre & (dut_q != 16'h0000) & (dut_q >= per_q));

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      per_q <= {8'h00, `PWM_PER_RST};
      dut_q <= {8'h00, `PWM_DUTY_RST};
      down_q <= 1'b0;
      wave_q <= 1'b0;
    end else begin
      wave_q <= (en & duty_on) ~^ pol;
      if (!en) begin
        cnt_q <= 16'h0000;
        down_q <= 1'b0;
        per_q <= per_buf;
        dut_q <= dut_buf;
      end else if (tick) begin
        if (!centre) begin
          if (at_top) begin
            cnt_q <= 16'h0000;
            per_q <= per_buf;
            dut_q <= dut_buf;
          end else begin
            cnt_q <= cnt_inc[15:0];
          end
        end else if (!down_q) begin
          if (at_top) begin
            cnt_q <= per_q;
            down_q <= 1'b1;
          end else begin
            cnt_q <= cnt_inc[15:0];
          end
        end else if (cnt_q <= 16'h0001) begin
          cnt_q <= 16'h0000;
          down_q <= 1'b0;
          per_q <= per_buf;
          dut_q <= dut_buf;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end
endmodule // pwm_chan

// [hdl/pwm_top.v]
// Six-channel pulse-width modulator with AXI4-Lite register slave
// Function
// - six channels, only zero to three reach pins
// - channel five shutdown unused, no output effect
// - each channel owns counter, period and duty
// - counters pick one of four clock sources
// - duty spans never-on through always-on
// - left or centre alignment per channel
// - independent software enable per channel
// - per-channel polarity of the duty portion
// - period and duty load at zero or disable
// - channel pairs concatenate into sixteen-bit channel
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pwm_map.vh"

module pwm_top (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Modulator outputs
  output reg [`PWM_NOUT-1:0] pwm_out
);
  // Control registers
  reg [5:0] en_q;
  reg [5:0] pol_q;
  reg [5:0] ctr_q;
  reg [2:0] cat_q;
  reg [11:0] clksel_q;
  reg [2:0] a_exp_q;
  reg [2:0] b_exp_q;
  reg [7:0] scl_a_q;
  reg [7:0] scl_b_q;
  reg [7:0] per_buf_q [0:`PWM_NCH-1];
  reg [7:0] dut_buf_q [0:`PWM_NCH-1];

  // Write channel capture
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_got_q;
  reg w_got_q;

  wire [3:0] tick;
  wire [`PWM_NCH-1:0] wave;
  wire [`PWM_NCH-1:0] run;
  wire [16*`PWM_NCH-1:0] cnt_bus;

  pwm_clkgen u_clkgen (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .a_exp(a_exp_q),
    .b_exp(b_exp_q),
    .scl_a(scl_a_q),
    .scl_b(scl_b_q),
    .tick(tick)
  );

  genvar i;
  generate
    for (i = 0; i < `PWM_NCH; i = i + 1) begin : g_ch
      localparam integer ODD = i % 2;
      localparam integer EVN = i - ODD;
      wire cat = cat_q[i/2];
      // Odd member of a joined pair runs 16 bits, the even member is held idle
      wire [15:0] per_v = (ODD == 1 && cat) ?
                          {per_buf_q[EVN], per_buf_q[i]} :
                          {8'h00, per_buf_q[i]};
      wire [15:0] dut_v = (ODD == 1 && cat) ?
                          {dut_buf_q[EVN], dut_buf_q[i]} :
                          {8'h00, dut_buf_q[i]};
      assign run[i] = en_q[i] & ~(ODD == 0 && cat);
      pwm_chan u_chan (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tick[clksel_q[2*i +: 2]]),
        .en(run[i]),
        .pol(pol_q[i]),
        .centre(ctr_q[i]),
        .per_buf(per_v),
        .dut_buf(dut_v),
        .wave_q(wave[i]),
        .cnt_q(cnt_bus[16*i +: 16])
      );
    end
  endgenerate

  // Channels four and five keep running but have no pin; no shutdown input exists
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out <= {`PWM_NOUT{1'b0}};
    end else begin
      pwm_out <= wave[`PWM_NOUT-1:0];
    end
  end

  // Write decode
  wire [7:0] wa = {awaddr_q[7:2], 2'b00};
  wire [7:0] wper_off = wa - `PWM_PER_BASE;
  wire [7:0] wdut_off = wa - `PWM_DUTY_BASE;
  wire w_per = (wa >= `PWM_PER_BASE) && (wa < `PWM_DUTY_BASE);
  wire w_dut = (wa >= `PWM_DUTY_BASE) && (wa < `PWM_CNT_BASE);
  // Status and counter words are read-only, so writes there are refused
  wire w_ok = (wa == `PWM_CTRL_OFF) ||
              (wa == `PWM_CLKSEL_OFF) ||
              (wa == `PWM_PRESC_OFF) ||
              w_per ||
              w_dut;
  wire do_wr = aw_got_q & w_got_q & ~s_axi_bvalid;
  integer n;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PWM_RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      // Address and data are taken in either order; response waits for both
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? `PWM_RESP_OKAY : `PWM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register writes; period and duty go to buffers the channels pick up at period end, the other fields act at once
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= `PWM_EN_RST;
      pol_q <= `PWM_POL_RST;
      ctr_q <= `PWM_CTR_RST;
      cat_q <= `PWM_CAT_RST;
      clksel_q <= `PWM_CLKSEL_RST;
      a_exp_q <= `PWM_EXP_RST;
      b_exp_q <= `PWM_EXP_RST;
      scl_a_q <= `PWM_SCL_RST;
      scl_b_q <= `PWM_SCL_RST;
      for (n = 0; n < `PWM_NCH; n = n + 1) begin
        per_buf_q[n] <= `PWM_PER_RST;
        dut_buf_q[n] <= `PWM_DUTY_RST;
      end
    end else if (do_wr) begin
      if (wa == `PWM_CTRL_OFF) begin
        if (wstrb_q[0]) begin
          en_q <= wdata_q[`PWM_EN_LSB +: 6];
        end
        if (wstrb_q[1]) begin
          pol_q <= wdata_q[`PWM_POL_LSB +: 6];
        end
        if (wstrb_q[2]) begin
          ctr_q <= wdata_q[`PWM_CTR_LSB +: 6];
        end
        if (wstrb_q[3]) begin
          cat_q <= wdata_q[`PWM_CAT_LSB +: 3];
        end
      end else if (wa == `PWM_CLKSEL_OFF) begin
        if (wstrb_q[0]) begin
          clksel_q[7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          clksel_q[11:8] <= wdata_q[11:8];
        end
      end else if (wa == `PWM_PRESC_OFF) begin
        if (wstrb_q[0]) begin
          a_exp_q <= wdata_q[`PWM_AEXP_LSB +: 3];
          b_exp_q <= wdata_q[`PWM_BEXP_LSB +: 3];
        end
        if (wstrb_q[1]) begin
          scl_a_q <= wdata_q[`PWM_SCLA_LSB +: 8];
        end
        if (wstrb_q[2]) begin
          scl_b_q <= wdata_q[`PWM_SCLB_LSB +: 8];
        end
      end else if (w_per) begin
        if (wstrb_q[0]) begin
          per_buf_q[wper_off[4:2]] <= wdata_q[7:0];
        end
      end else if (w_dut) begin
        if (wstrb_q[0]) begin
          dut_buf_q[wdut_off[4:2]] <= wdata_q[7:0];
        end
      end
    end
  end

  // Read decode
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [7:0] rper_off = ra - `PWM_PER_BASE;
  wire [7:0] rdut_off = ra - `PWM_DUTY_BASE;
  wire [7:0] rcnt_off = ra - `PWM_CNT_BASE;
  reg [31:0] rd_data;
  reg rd_err;

  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (ra == `PWM_CTRL_OFF) begin
      rd_data[`PWM_EN_LSB +: 6] = en_q;
      rd_data[`PWM_POL_LSB +: 6] = pol_q;
      rd_data[`PWM_CTR_LSB +: 6] = ctr_q;
      rd_data[`PWM_CAT_LSB +: 3] = cat_q;
    end else if (ra == `PWM_CLKSEL_OFF) begin
      rd_data[11:0] = clksel_q;
    end else if (ra == `PWM_PRESC_OFF) begin
      rd_data[`PWM_AEXP_LSB +: 3] = a_exp_q;
      rd_data[`PWM_BEXP_LSB +: 3] = b_exp_q;
      rd_data[`PWM_SCLA_LSB +: 8] = scl_a_q;
      rd_data[`PWM_SCLB_LSB +: 8] = scl_b_q;
    end else if (ra == `PWM_STAT_OFF) begin
      rd_data[5:0] = run;
      rd_data[`PWM_OUT_LSB +: `PWM_NOUT] = pwm_out;
    end else if ((ra >= `PWM_PER_BASE) && (ra < `PWM_DUTY_BASE)) begin
      rd_data[7:0] = per_buf_q[rper_off[4:2]];
    end else if ((ra >= `PWM_DUTY_BASE) && (ra < `PWM_CNT_BASE)) begin
      rd_data[7:0] = dut_buf_q[rdut_off[4:2]];
    end else if ((ra >= `PWM_CNT_BASE) && (ra < `PWM_MAP_END)) begin
      rd_data[15:0] = cnt_bus[16*rcnt_off[4:2] +: 16];
    end else begin
      rd_err = 1'b1;
    end
  end

  // Read channel: one answer outstanding; data is frozen so a slow master sees a stable word
  localparam RD_IDLE = 1'b0;
  localparam RD_RESP = 1'b1;
  reg rd_state_q;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_q <= RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PWM_RESP_OKAY;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (s_axi_arvalid && s_axi_arready) begin
            rd_state_q <= RD_RESP;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `PWM_RESP_SLVERR : `PWM_RESP_OKAY;
          end
        end
        RD_RESP: begin
          if (s_axi_rvalid && s_axi_rready) begin
            rd_state_q <= RD_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
        default: begin
          rd_state_q <= RD_IDLE;
        end
      endcase
    end
  end
endmodule // pwm_top

// [verification/pwm_top_chk.sv]
// Bus handshake and output checker for the modulator top
`timescale 1ns/1ps
module pwm_top_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Pins
  input wire [3:0] pwm_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_rd_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
    else $error("write channels not reopened");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h58
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_idle_low: assert property ($rose(rst_n) |-> (pwm_out == 4'h0) [*3])
    else $error("output active after reset");
endmodule // pwm_top_chk

bind pwm_top pwm_top_chk pwm_top_chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pwm_out(pwm_out));

// [verification/pwm_top_bench.sv]
// Self-checking bench for the modulator top
`timescale 1ns/1ps
`include "pwm_map.vh"
module pwm_top_bench;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] pwm_out;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int hc[4];
  int rc;

  always #4 clk_sys = ~clk_sys;

  pwm_top pwm_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pwm_out(pwm_out));

  task stop_test;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  // Whole run needs under two thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests++;
      if (got !== exp) begin
        fail_count++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Entered just after a rising edge; address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic dd;
    begin
      ad = 1'h0;
      dd = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (!(ad && dd)) begin
        @(posedge clk_sys);
        if (s_axi_awready === 1'h1 && !ad) begin
          ad = 1'h1;
          s_axi_awvalid <= 1'h0;
        end
        if (s_axi_wready === 1'h1 && !dd) begin
          dd = 1'h1;
          s_axi_wvalid <= 1'h0;
        end
      end
      s_axi_bready <= 1'h1;
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(32'(s_axi_bresp), 32'(er));
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
    end
  endtask

  // High cycles per pin and rising edges of pin 0 over n clocks
  task meas(input int n);
    logic p;
    begin
      hc = '{default: 0};
      rc = 0;
      p = pwm_out[0];
      repeat (n) begin
        @(posedge clk_sys);
        for (int k = 0; k < 4; k++) hc[k] += int'(pwm_out[k]);
        if (pwm_out[0] && !p) rc++;
        p = pwm_out[0];
      end
    end
  endtask

  task t_reset;
    begin
      chk(32'(pwm_out), 32'h0);
      rd(`PWM_CTRL_OFF, 32'h00003F00, `PWM_RESP_OKAY);
      rd(`PWM_PER_BASE, 32'h000000FF, `PWM_RESP_OKAY);
      rd(`PWM_MAP_END, 32'h0, `PWM_RESP_SLVERR);
      rd(`PWM_STAT_OFF, 32'h0, `PWM_RESP_OKAY);
      rd(`PWM_CNT_BASE, 32'h0, `PWM_RESP_OKAY);
      wr(`PWM_CNT_BASE, 32'h0, `PWM_RESP_SLVERR);
      // Only the polarity byte is strobed
      s_axi_wstrb <= 4'h2;
      wr(`PWM_CTRL_OFF, 32'h0F0F0F0F, `PWM_RESP_OKAY);
      rd(`PWM_CTRL_OFF, 32'h00000F00, `PWM_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      wr(`PWM_CTRL_OFF, 32'h00003F00, `PWM_RESP_OKAY);
      wr(`PWM_STAT_OFF, 32'h0, `PWM_RESP_SLVERR);
      wr(`PWM_MAP_END, 32'h0, `PWM_RESP_SLVERR);
    end
  endtask

  task t_left;
    int per[4];
    int dut[4];
    begin
      per = '{10, 4, 4, 4};
      dut = '{3, 0, 255, 1};
      for (int k = 0; k < 4; k++) begin
        wr(8'(`PWM_PER_BASE + 4 * k), 32'(per[k]), `PWM_RESP_OKAY);
        wr(8'(`PWM_DUTY_BASE + 4 * k), 32'(dut[k]), `PWM_RESP_OKAY);
      end
      // Channel 3 has its duty portion driven low; channel 5 runs but must not reach a pin
      wr(`PWM_CTRL_OFF, 32'h0000372F, `PWM_RESP_OKAY);
      repeat (40) @(posedge clk_sys);
      meas(100);
      chk(hc[0], 30);
      chk(hc[1], 0);
      chk(hc[2], 100);
      chk(hc[3], 75);
      wr(`PWM_DUTY_BASE, 32'h7, `PWM_RESP_OKAY);
      repeat (20) @(posedge clk_sys);
      meas(100);
      chk(hc[0], 70);
    end
  endtask

  task t_centre;
    begin
      wr(`PWM_CTRL_OFF, 32'h00003F00, `PWM_RESP_OKAY);
      wr(`PWM_PER_BASE, 32'h5, `PWM_RESP_OKAY);
      wr(`PWM_DUTY_BASE, 32'h2, `PWM_RESP_OKAY);
      wr(`PWM_CTRL_OFF, 32'h00013F01, `PWM_RESP_OKAY);
      repeat (40) @(posedge clk_sys);
      meas(100);
      chk(hc[0], 30);
      chk(rc, 10);
    end
  endtask

  task t_clk;
    int dv[4];
    begin
      dv = '{1, 2, 2, 4};
      // Primary A every clock, B every second, both scaled by two
      wr(`PWM_PRESC_OFF, 32'h00010110, `PWM_RESP_OKAY);
      wr(`PWM_CTRL_OFF, 32'h00003F01, `PWM_RESP_OKAY);
      for (int s = 0; s < 4; s++) begin
        wr(`PWM_CLKSEL_OFF, 32'(s), `PWM_RESP_OKAY);
        repeat (40) @(posedge clk_sys);
        meas(200);
        chk(rc, 40 / dv[s]);
        chk(hc[0], 80);
      end
    end
  endtask

  task t_cat;
    begin
      wr(`PWM_CTRL_OFF, 32'h00003F00, `PWM_RESP_OKAY);
      wr(`PWM_PER_BASE, 32'h0, `PWM_RESP_OKAY);
      wr(`PWM_PER_BASE + 8'h04, 32'h14, `PWM_RESP_OKAY);
      wr(`PWM_DUTY_BASE, 32'h0, `PWM_RESP_OKAY);
      wr(`PWM_DUTY_BASE + 8'h04, 32'h5, `PWM_RESP_OKAY);
      wr(`PWM_CTRL_OFF, 32'h01003F02, `PWM_RESP_OKAY);
      repeat (60) @(posedge clk_sys);
      meas(100);
      chk(hc[1], 25);
      chk(hc[0], 0);
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    t_reset();
    t_left();
    t_centre();
    t_clk();
    t_cat();
    stop_test();
  end
endmodule // pwm_top_bench
